/* File: rtl/amp_consts.vh */
// Constants of the per-axis motion parameter register bank.
// Assumes inclusion by the bank module, its monitor and its bench.
`ifndef AMP_CONSTS_VH
`define AMP_CONSTS_VH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define AMP_ADDR_W 4
`define AMP_IDX_CCMF 4'h0
`define AMP_IDX_CCMF_PRE2 4'h1
`define AMP_IDX_ACCEL 4'h2
`define AMP_IDX_ACCEL_PRE2 4'h3
`define AMP_IDX_DECEL 4'h4
`define AMP_IDX_DECEL_PRE2 4'h5
`define AMP_IDX_CORR 4'h6
`define AMP_IDX_ENV1 4'h7
`define AMP_IDX_MOTION 4'h8
`define AMP_IDX_HIGHFEED 4'h9
`define AMP_IDX_LOWFEED 4'ha
`define AMP_IDX_SCALE 4'hb
`define AMP_IDX_STATUS 4'hc
// ----------------------------------------
// Field layout
// ----------------------------------------
`define AMP_CCMF_W 28
`define AMP_SPAN_W 15
`define AMP_CORR_W 16
`define AMP_FEED_W 16
`define AMP_SCALE_W 16
`define AMP_KIND_W 7
`define AMP_KIND_LIN2_CONT 7'h62
`define AMP_KIND_LIN2 7'h63
`define AMP_KIND_CW 7'h64
`define AMP_KIND_CCW 7'h65
`define AMP_PMD_LSB 0
`define AMP_PMD_MSB 2
`define AMP_ELM_BIT 3
`define AMP_EPW_LSB 12
`define AMP_EPW_MSB 14
`define AMP_ERROR_CLEAR_OUTPUT_LOGIC_BIT 15
// ----------------------------------------
// Reset values
// ----------------------------------------
`define AMP_RST_WORD 32'h0000_0000
`define AMP_RST_SCALE 16'h012c
`endif

/* File: rtl/amp_param_regs.v */
// Per-axis motion parameter register bank with second-level pre-registers.
// Assumes a single-cycle CPU port on mclk and a pulse generator consuming the outputs.
//
// How it works
// RL1: centre/feed word only valid in operation kinds 62h to 65h, else zero.
// RL2: in kinds 62h and 63h the word is incremental master feed.
// RL3: in kinds 64h and 65h the word is absolute circle centre.
// RL4: software keeps the written word within plus or minus 134,217,727.
// RL5: bits 31 to 28 ignore writes and read as sign of bit 27.
// RL6: unused upper bits of span and speed registers read zero.
// RL7: acceleration span comes from the acceleration span register.
// RL8: zero acceleration span means use half of high minus low feed.
// RL9: deceleration span comes from the deceleration span register.
// RL10: zero deceleration span means use half of high minus low feed.
// RL11: correction low speed applies to backlash and slip correction.
// RL12: correction low speed is also the zero-return reverse low speed.
// RL13: correction speed is scaled by the speed-scale register.
// RL14: centre/feed and both spans each have a second pre-register.
// RL15: environment word holds pulse format, error-clear width and logic.
// RL16: environment bit 3 selects immediate or decelerating end-limit stop.
// RL17: pre-register values move to working registers when next move starts.
// RL18: low 28 bits of centre/feed word are two's complement.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "amp_consts.vh"
module amp_param_regs #(
   parameter CCMF_W = `AMP_CCMF_W,
   parameter SPAN_W = `AMP_SPAN_W,
   parameter CORR_W = `AMP_CORR_W,
   parameter FEED_W = `AMP_FEED_W
) (
   input wire mclk,
   input wire rst_n,
   input wire [`AMP_ADDR_W-1:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdata,
   input wire nextMoveStart,
   input wire correctionActive,
   input wire zeroReturnReverse,
   output reg [CCMF_W-1:0] masterFeedAmount,
   output reg masterFeedValid,
   output reg [CCMF_W-1:0] circleCenterPos,
   output reg circleCenterValid,
   output reg [SPAN_W-1:0] accelSpanEff,
   output reg [SPAN_W-1:0] decelSpanEff,
   output reg [CORR_W+`AMP_SCALE_W-1:0] lowSpeedRate,
   output reg lowSpeedActive,
   output reg [2:0] pulseOutputFormat,
   output reg [2:0] errorClearPulseWidth,
   output reg errorClearOutputLogic,
   output reg endLimitStopMethod
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [SPAN_W-1:0] spanPick;
      input [SPAN_W-1:0] span;
      input [FEED_W-1:0] hi;
      input [FEED_W-1:0] lo;
      reg [FEED_W-1:0] diff;
      begin
         diff = (hi > lo) ? (hi - lo) : {FEED_W{1'b0}};
         if (span == {SPAN_W{1'b0}}) begin
            spanPick = diff[SPAN_W:1];
         end else begin
            spanPick = span;
         end
      end
   endfunction

   function [31:0] signExt;
      input [CCMF_W-1:0] v;
      begin
         signExt = {{(32-CCMF_W){v[CCMF_W-1]}}, v};
      end
   endfunction

   function hitIdx;
      input [`AMP_ADDR_W-1:0] addr;
      input [`AMP_ADDR_W-1:0] idx;
      begin
         hitIdx = addr == idx;
      end
   endfunction

   function [31:0] spanWord;
      input [SPAN_W-1:0] v;
      begin
         spanWord = {{(32-SPAN_W){1'b0}}, v};
      end
   endfunction

   function [31:0] feedWord;
      input [FEED_W-1:0] v;
      begin
         feedWord = {{(32-FEED_W){1'b0}}, v};
      end
   endfunction

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   reg [CCMF_W-1:0] ccmf_reg, ccmfPre2_reg;
   reg ccmfPend_reg;
   reg [SPAN_W-1:0] accel_reg, accelPre2_reg;
   reg accelPend_reg;
   reg [SPAN_W-1:0] decel_reg, decelPre2_reg;
   reg decelPend_reg;
   reg [CORR_W-1:0] corr_reg;
   reg [31:0] env1_reg;
   reg [`AMP_KIND_W-1:0] kind_reg;
   reg [FEED_W-1:0] highFeed_reg, lowFeed_reg;
   reg [`AMP_SCALE_W-1:0] scale_reg;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire wrHit0 = regWr && hitIdx(regAddr, `AMP_IDX_CCMF);
   wire wrHit1 = regWr && hitIdx(regAddr, `AMP_IDX_CCMF_PRE2);
   wire wrHit2 = regWr && hitIdx(regAddr, `AMP_IDX_ACCEL);
   wire wrHit3 = regWr && hitIdx(regAddr, `AMP_IDX_ACCEL_PRE2);
   wire wrHit4 = regWr && hitIdx(regAddr, `AMP_IDX_DECEL);
   wire wrHit5 = regWr && hitIdx(regAddr, `AMP_IDX_DECEL_PRE2);
   wire wrCorr = regWr && hitIdx(regAddr, `AMP_IDX_CORR);
   wire wrEnv1 = regWr && hitIdx(regAddr, `AMP_IDX_ENV1);
   wire wrKind = regWr && hitIdx(regAddr, `AMP_IDX_MOTION);
   wire wrHigh = regWr && hitIdx(regAddr, `AMP_IDX_HIGHFEED);
   wire wrLow = regWr && hitIdx(regAddr, `AMP_IDX_LOWFEED);
   wire wrScale = regWr && hitIdx(regAddr, `AMP_IDX_SCALE);

   // Queued values move only if written since the last start
   wire xferCcmf = nextMoveStart && ccmfPend_reg; // RL17
   wire xferAccel = nextMoveStart && accelPend_reg; // RL17
   wire xferDecel = nextMoveStart && decelPend_reg; // RL17

   // Pending flags as software sees them
   wire [2:0] pendFlags = {decelPend_reg, accelPend_reg, ccmfPend_reg};

   // ----------------------------------------
   // Centre/feed word and its pre-register
   // ----------------------------------------
   // Pre2 write wins over a same-cycle start
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ccmfPre2_reg <= {CCMF_W{1'b0}};
         ccmfPend_reg <= 1'b0;
      end else if (wrHit1) begin
         ccmfPre2_reg <= regWdata[CCMF_W-1:0]; // RL5 RL14
         ccmfPend_reg <= 1'b1;
      end else if (nextMoveStart) begin
         ccmfPend_reg <= 1'b0; // RL17
      end
   end

   // Direct write wins over the transfer
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ccmf_reg <= {CCMF_W{1'b0}};
      end else if (wrHit0) begin
         ccmf_reg <= regWdata[CCMF_W-1:0]; // RL5
      end else if (xferCcmf) begin
         ccmf_reg <= ccmfPre2_reg; // RL17
      end
   end

   // ----------------------------------------
   // Acceleration span and its pre-register
   // ----------------------------------------
   // Pre2 write wins over a same-cycle start
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         accelPre2_reg <= {SPAN_W{1'b0}};
         accelPend_reg <= 1'b0;
      end else if (wrHit3) begin
         accelPre2_reg <= regWdata[SPAN_W-1:0]; // RL6 RL14
         accelPend_reg <= 1'b1;
      end else if (nextMoveStart) begin
         accelPend_reg <= 1'b0; // RL17
      end
   end

   // Direct write wins over the transfer
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         accel_reg <= {SPAN_W{1'b0}};
      end else if (wrHit2) begin
         accel_reg <= regWdata[SPAN_W-1:0]; // RL6
      end else if (xferAccel) begin
         accel_reg <= accelPre2_reg; // RL17
      end
   end

   // ----------------------------------------
   // Deceleration span and its pre-register
   // ----------------------------------------
   // Pre2 write wins over a same-cycle start
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         decelPre2_reg <= {SPAN_W{1'b0}};
         decelPend_reg <= 1'b0;
      end else if (wrHit5) begin
         decelPre2_reg <= regWdata[SPAN_W-1:0]; // RL6 RL14
         decelPend_reg <= 1'b1;
      end else if (nextMoveStart) begin
         decelPend_reg <= 1'b0; // RL17
      end
   end

   // Direct write wins over the transfer
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         decel_reg <= {SPAN_W{1'b0}};
      end else if (wrHit4) begin
         decel_reg <= regWdata[SPAN_W-1:0]; // RL6
      end else if (xferDecel) begin
         decel_reg <= decelPre2_reg; // RL17
      end
   end

   // ----------------------------------------
   // Plain registers
   // ----------------------------------------
   // Status index has no storage; writes there drop
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         corr_reg <= {CORR_W{1'b0}};
      end else if (wrCorr) begin
         corr_reg <= regWdata[CORR_W-1:0]; // RL6
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         env1_reg <= `AMP_RST_WORD;
      end else if (wrEnv1) begin
         env1_reg <= regWdata; // RL15
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         kind_reg <= {`AMP_KIND_W{1'b0}};
      end else if (wrKind) begin
         kind_reg <= regWdata[`AMP_KIND_W-1:0];
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         highFeed_reg <= {FEED_W{1'b0}};
      end else if (wrHigh) begin
         highFeed_reg <= regWdata[FEED_W-1:0];
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lowFeed_reg <= {FEED_W{1'b0}};
      end else if (wrLow) begin
         lowFeed_reg <= regWdata[FEED_W-1:0];
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scale_reg <= `AMP_RST_SCALE;
      end else if (wrScale) begin
         scale_reg <= regWdata[`AMP_SCALE_W-1:0]; // RL13
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   reg [31:0] rdMux;
   always @* begin
      rdMux = 32'h0000_0000;
      case (regAddr)
         `AMP_IDX_CCMF: rdMux = signExt(ccmf_reg); // RL5
         `AMP_IDX_CCMF_PRE2: rdMux = signExt(ccmfPre2_reg); // RL5
         `AMP_IDX_ACCEL: rdMux = spanWord(accel_reg); // RL6
         `AMP_IDX_ACCEL_PRE2: rdMux = spanWord(accelPre2_reg); // RL6
         `AMP_IDX_DECEL: rdMux = spanWord(decel_reg); // RL6
         `AMP_IDX_DECEL_PRE2: rdMux = spanWord(decelPre2_reg); // RL6
         `AMP_IDX_CORR: rdMux = {{(32-CORR_W){1'b0}}, corr_reg}; // RL6
         `AMP_IDX_ENV1: rdMux = env1_reg;
         `AMP_IDX_MOTION: rdMux = {{(32-`AMP_KIND_W){1'b0}}, kind_reg};
         `AMP_IDX_HIGHFEED: rdMux = feedWord(highFeed_reg);
         `AMP_IDX_LOWFEED: rdMux = feedWord(lowFeed_reg);
         `AMP_IDX_SCALE: rdMux = {{(32-`AMP_SCALE_W){1'b0}}, scale_reg};
         `AMP_IDX_STATUS: rdMux = {29'h0000_0000, pendFlags};
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 32'h0000_0000;
      end else if (regRd) begin
         regRdata <= rdMux;
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Centre/feed routing by operation kind
   // ----------------------------------------
   wire isLin2 = kind_reg == `AMP_KIND_LIN2_CONT || kind_reg == `AMP_KIND_LIN2; // RL1
   wire isCirc = kind_reg == `AMP_KIND_CW || kind_reg == `AMP_KIND_CCW; // RL1

   // Signed 28-bit word, zero outside its kinds
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         masterFeedAmount <= {CCMF_W{1'b0}};
         masterFeedValid <= 1'b0;
         circleCenterPos <= {CCMF_W{1'b0}};
         circleCenterValid <= 1'b0;
      end else begin
         masterFeedAmount <= isLin2 ? ccmf_reg : {CCMF_W{1'b0}}; // RL1 RL2 RL18
         masterFeedValid <= isLin2; // RL2
         circleCenterPos <= isCirc ? ccmf_reg : {CCMF_W{1'b0}}; // RL1 RL3 RL18
         circleCenterValid <= isCirc; // RL3
      end
   end

   // ----------------------------------------
   // Effective S-curve spans
   // ----------------------------------------
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         accelSpanEff <= {SPAN_W{1'b0}};
         decelSpanEff <= {SPAN_W{1'b0}};
      end else begin
         accelSpanEff <= spanPick(accel_reg, highFeed_reg, lowFeed_reg); // RL7 RL8
         decelSpanEff <= spanPick(decel_reg, highFeed_reg, lowFeed_reg); // RL9 RL10
      end
   end

   // ----------------------------------------
   // Correction low speed
   // ----------------------------------------
   // Widened factors keep the full product
   wire [CORR_W+`AMP_SCALE_W-1:0] corrWide = {{`AMP_SCALE_W{1'b0}}, corr_reg};
   wire [CORR_W+`AMP_SCALE_W-1:0] scaleWide = {{CORR_W{1'b0}}, scale_reg};

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lowSpeedRate <= {(CORR_W+`AMP_SCALE_W){1'b0}};
         lowSpeedActive <= 1'b0;
      end else begin
         lowSpeedRate <= corrWide * scaleWide; // RL13
         lowSpeedActive <= correctionActive | zeroReturnReverse; // RL11 RL12
      end
   end

   // ----------------------------------------
   // Environment word fields
   // ----------------------------------------
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pulseOutputFormat <= 3'h0;
         errorClearPulseWidth <= 3'h0;
         errorClearOutputLogic <= 1'b0;
         endLimitStopMethod <= 1'b0;
      end else begin
         pulseOutputFormat <= env1_reg[`AMP_PMD_MSB:`AMP_PMD_LSB]; // RL15
         errorClearPulseWidth <= env1_reg[`AMP_EPW_MSB:`AMP_EPW_LSB]; // RL15
         errorClearOutputLogic <= env1_reg[`AMP_ERROR_CLEAR_OUTPUT_LOGIC_BIT]; // RL15
         endLimitStopMethod <= env1_reg[`AMP_ELM_BIT]; // RL16
      end
   end

endmodule

/* File: tb/amp_param_regs_monitor.sv */
// Port checks for the motion parameter bank.
// Assumes binding into amp_param_regs.
`timescale 1ns/1ps
`include "amp_consts.vh"
module amp_param_regs_monitor #(
   parameter CCMF_W = 28,
   parameter SPAN_W = 15
) (
   input logic mclk,
   input logic rst_n,
   input logic [3:0] regAddr,
   input logic [31:0] regWdata,
   input logic regWr,
   input logic regRd,
   input logic [31:0] regRdata,
   input logic nextMoveStart,
   input logic correctionActive,
   input logic zeroReturnReverse,
   input logic [CCMF_W-1:0] masterFeedAmount,
   input logic masterFeedValid,
   input logic [CCMF_W-1:0] circleCenterPos,
   input logic circleCenterValid,
   input logic [SPAN_W-1:0] accelSpanEff,
   input logic lowSpeedActive,
   input logic [2:0] pulseOutputFormat,
   input logic [2:0] errorClearPulseWidth,
   input logic errorClearOutputLogic,
   input logic endLimitStopMethod
);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire wrK = regWr && regAddr == `AMP_IDX_MOTION;
   wire wrS = regWr && regAddr == `AMP_IDX_ACCEL;
   wire wrE = regWr && regAddr == `AMP_IDX_ENV1;
   AST_SIGN: assert property (regRd && regAddr == `AMP_IDX_CCMF |=>
      regRdata[31:28] == {4{regRdata[27]}}) else $error("centre word sign bits wrong");
   AST_SPAN_HI: assert property (regRd && regAddr inside {[2:5]} |=> regRdata[31:15] == 0)
      else $error("span upper bits not zero");
   AST_CORR_HI: assert property (regRd && regAddr == `AMP_IDX_CORR |=> regRdata[31:16] == 0)
      else $error("speed upper bits not zero");
   AST_GATE: assert property ((masterFeedValid || masterFeedAmount == 0) &&
      (circleCenterValid || circleCenterPos == 0)) else $error("centre word leaks");
   AST_EXCL: assert property (!(masterFeedValid && circleCenterValid)) else $error("both uses valid");
   AST_LIN2: assert property (wrK && regWdata[6:0] inside {7'h62, 7'h63} ##1 !wrK |=>
      masterFeedValid && !circleCenterValid) else $error("feed use missing");
   AST_CIRC: assert property (wrK && regWdata[6:0] inside {7'h64, 7'h65} ##1 !wrK |=>
      circleCenterValid && !masterFeedValid) else $error("centre use missing");
   AST_SPAN: assert property (wrS && regWdata[14:0] != 0 ##1 !(wrS || nextMoveStart) |=>
      accelSpanEff == $past(regWdata[14:0], 2)) else $error("accel span wrong");
   AST_ENV: assert property (wrE ##1 !wrE |=> {errorClearOutputLogic, errorClearPulseWidth,
      endLimitStopMethod, pulseOutputFormat} == {$past(regWdata[15:12], 2), $past(regWdata[3:0], 2)})
      else $error("env fields wrong");
   AST_LOW: assert property ($rose(correctionActive || zeroReturnReverse) |=> lowSpeedActive)
      else $error("low speed not active");
   cover property (masterFeedValid);
   cover property (circleCenterValid);
   cover property (nextMoveStart ##2 regRd);
endmodule
bind amp_param_regs amp_param_regs_monitor #(.CCMF_W(CCMF_W), .SPAN_W(SPAN_W)) amp_param_regs_monitor_i (.*);

/* File: tb/amp_param_regs_tb.sv */
// Self-checking bench for the motion parameter bank.
// Assumes the bank and its monitor are compiled first.
`timescale 1ns/1ps
`include "amp_consts.vh"
module amp_param_regs_tb;
   logic mclk, rst_n, regWr, regRd, nextMoveStart, correctionActive, zeroReturnReverse;
   logic [3:0] regAddr;
   logic [31:0] regWdata, regRdata, lowSpeedRate;
   logic [27:0] masterFeedAmount, circleCenterPos;
   logic [14:0] accelSpanEff, decelSpanEff;
   logic [2:0] pulseOutputFormat, errorClearPulseWidth;
   logic masterFeedValid, circleCenterValid, lowSpeedActive, errorClearOutputLogic, endLimitStopMethod;
   logic lin, circ;
   logic [6:0] kinds [6] = '{7'h61, 7'h62, 7'h63, 7'h64, 7'h65, 7'h66};
   int n_errors = 0;
   int total_checks = 0;
   amp_param_regs amp_param_regs_i (.*);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      chk(regRdata, exp);
   endtask
   task automatic settle();
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic lvl(input logic c, input logic z);
      @(posedge mclk);
      correctionActive <= c;
      zeroReturnReverse <= z;
      settle();
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, watchdog, tests
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim();
   end
   initial begin
      rst_n = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 4'h0;
      regWdata = 32'h0;
      nextMoveStart = 1'b0;
      correctionActive = 1'b0;
      zeroReturnReverse = 1'b0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      rdc(`AMP_IDX_SCALE, 32'h12c);
      rdc(4'hd, 32'h0);
      $display("test reset done");
      wr(`AMP_IDX_CCMF, 32'h0800_0005);
      rdc(`AMP_IDX_CCMF, 32'hf800_0005);
      wr(`AMP_IDX_CCMF, 32'hf000_0123);
      rdc(`AMP_IDX_CCMF, 32'h0000_0123);
      wr(`AMP_IDX_ACCEL, 32'hffff_ffff);
      rdc(`AMP_IDX_ACCEL, 32'h7fff);
      wr(`AMP_IDX_CORR, 32'hffff_ffff);
      rdc(`AMP_IDX_CORR, 32'hffff);
      $display("test masking done");
      for (int i = 0; i < 6; i++) begin
         wr(`AMP_IDX_MOTION, {25'h0, kinds[i]});
         settle();
         lin = kinds[i] == 7'h62 || kinds[i] == 7'h63;
         circ = kinds[i] == 7'h64 || kinds[i] == 7'h65;
         chk({30'h0, masterFeedValid, circleCenterValid}, {30'h0, lin, circ});
         chk(masterFeedAmount, lin ? 32'h123 : 32'h0);
         chk(circleCenterPos, circ ? 32'h123 : 32'h0);
      end
      $display("test kinds done");
      wr(`AMP_IDX_MOTION, 32'h63);
      wr(`AMP_IDX_CCMF_PRE2, 32'h0fff_fffb);
      wr(`AMP_IDX_ACCEL_PRE2, 32'h7);
      wr(`AMP_IDX_DECEL_PRE2, 32'h9);
      rdc(`AMP_IDX_STATUS, 32'h7);
      rdc(`AMP_IDX_CCMF, 32'h123);
      @(posedge mclk);
      nextMoveStart <= 1'b1;
      @(posedge mclk);
      nextMoveStart <= 1'b0;
      rdc(`AMP_IDX_STATUS, 32'h0);
      rdc(`AMP_IDX_CCMF, 32'hffff_fffb);
      rdc(`AMP_IDX_DECEL, 32'h9);
      chk(masterFeedAmount, 32'h0fff_fffb);
      chk(accelSpanEff, 32'h7);
      $display("test preload done");
      wr(`AMP_IDX_HIGHFEED, 32'd100);
      wr(`AMP_IDX_LOWFEED, 32'd20);
      wr(`AMP_IDX_ACCEL, 32'h0);
      wr(`AMP_IDX_DECEL, 32'h0);
      settle();
      chk(accelSpanEff, 32'd40);
      chk(decelSpanEff, 32'd40);
      wr(`AMP_IDX_DECEL, 32'd300);
      settle();
      chk(decelSpanEff, 32'd300);
      wr(`AMP_IDX_LOWFEED, 32'd200);
      settle();
      chk(accelSpanEff, 32'h0);
      $display("test spans done");
      wr(`AMP_IDX_CORR, 32'd3);
      settle();
      chk(lowSpeedRate, 32'd900);
      wr(`AMP_IDX_SCALE, 32'h0001_0002);
      rdc(`AMP_IDX_SCALE, 32'h2);
      chk(lowSpeedRate, 32'd6);
      lvl(1'b1, 1'b0);
      chk(lowSpeedActive, 32'h1);
      lvl(1'b0, 1'b1);
      chk(lowSpeedActive, 32'h1);
      lvl(1'b0, 1'b0);
      chk(lowSpeedActive, 32'h0);
      $display("test speed done");
      wr(`AMP_IDX_ENV1, 32'ha5a5_d00d);
      rdc(`AMP_IDX_ENV1, 32'ha5a5_d00d);
      chk({errorClearOutputLogic, errorClearPulseWidth, endLimitStopMethod, pulseOutputFormat}, 32'hdd);
      $display("test env done");
      end_sim();
   end
endmodule
